// File: verilog/kill_defs.vh
`ifndef KILL_DEFS_VH
`define KILL_DEFS_VH

`define ADDR_CTRL 12'h000
`define ADDR_CMD 12'h004
`define ADDR_COND_EN 12'h008
`define ADDR_COND_ST 12'h00C
`define ADDR_RECOV 12'h010
`define ADDR_ISW 12'h014
`define ADDR_PSW 12'h018
`define ADDR_STAT 12'h01C
`define ADDR_IRQ_ST 12'h020
`define ADDR_IRQ_MASK 12'h024

`define CTRL_KEEP 0
`define CTRL_BGTASK 1
`define CTRL_DRAG 2

`define CMD_CODE_W 8
`define CMD_RESTART 8'h04
`define CMD_DRV_EN 8'h01
`define CMD_DRV_DIS 8'h02
`define CMD_TTP 8'h03
`define CMD_CIS 8'h05
`define CMD_CPL 8'h06

`define BIT_MOVE_ERR 4
`define BIT_HOLD_ERR 5
`define BIT_OVERVOLT 13

`define PSW_MOVE_ERR 0
`define PSW_HOLD_ERR 1
`define PSW_KILLED 2

`define IRQ_TRIP 0
`define IRQ_ERRLIM 1
`define IRQ_W 2

`define STAT_DRV 0
`define STAT_MOTION_OK 1
`define STAT_RECOV_RUN 2
`define STAT_ABORT 3
`define STAT_SHORT 4

`define DEFAULT_PROG 8'h00
`define RECOV_EN 8

`endif

// File: verilog/trip_match.v
`timescale 1ns/10ps
`include "kill_defs.vh"

module trip_match #(
    parameter W = 16
) (
    input wire [W-1:0] status,
    input wire [W-1:0] cond_en,
    input wire [W-1:0] cond_st,
    output wire trip
);
    wire [W-1:0] en_eff;
    // Over-voltage is always armed whatever software loads
    assign en_eff = cond_en | ({{(W-1){1'b0}}, 1'b1} << `BIT_OVERVOLT);
    assign trip = |(en_eff & ~(status ^ cond_st));
endmodule // trip_match

// File: verilog/kill_shutdown.v
// Functional notes
// - Default trip aborts motion, program, drops driver
// - Alternate trip keeps driver, starts recovery program
// - Background tasking with keep-driver lets motion finish unless overridden
// - Enable word selects evaluated status bits
// - State word gives triggering level per bit
// - Keep-driver works only with background tasking
// - Default drop option disables driver, shorts windings
// - Motion refused until enable-driver command
// - Error-limit trips flag internal and polling words
// - Host reads polling word to detect shutdown
// - Drag mode suppresses error-limit flags
// - Driver enabled out of reset
// - Recovery selects stored program to run
// - Restart code 4 resets all, jumps default
// - Target-to-actual clears accumulated position error
// - Clear-internal command clears moving-error bit
// - Over-voltage bit always enabled trip condition
`timescale 1ns/10ps
`include "kill_defs.vh"

module kill_shutdown #(
    parameter W = 16,
    parameter PERR_W = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [W-1:0] status_in,
    input wire move_err_event,
    input wire hold_err_event,
    input wire [PERR_W-1:0] pos_err_in,
    input wire motion_busy,
    input wire recov_override,
    output reg driver_enable_q,
    output reg winding_short_q,
    output reg motion_abort_q,
    output reg motion_allow_q,
    output reg recov_start_q,
    output reg [7:0] recov_prog_q,
    output reg restart_q,
    output reg pos_err_clear_q,
    output reg [PERR_W-1:0] pos_err_q,
    output wire irq
);
    reg [2:0] ctrl_q;
    reg [W-1:0] cond_en_q;
    reg [W-1:0] cond_st_q;
    reg [8:0] recov_q;
    reg [W-1:0] isw_q;
    reg [2:0] psw_q;
    reg [`IRQ_W-1:0] irq_st_q;
    reg [`IRQ_W-1:0] irq_mask_q;
    reg trip_prev_q;
    reg recov_run_q;
    wire [W-1:0] status_eff;
    wire trip;
    wire trip_rise;
    wire wr;
    wire rd;
    wire cmd_wr;
    wire [7:0] cmd;
    wire keep_drv;
    wire drag;
    wire mv_ev;
    wire hd_ev;
    wire mapped;
    wire rd_irq;

    function hit;
        input [11:0] a;
        input [11:0] r;
        begin
            hit = (a == r);
        end
    endfunction

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign mapped = hit(paddr, `ADDR_CTRL) | hit(paddr, `ADDR_CMD) |
        hit(paddr, `ADDR_COND_EN) | hit(paddr, `ADDR_COND_ST) |
        hit(paddr, `ADDR_RECOV) | hit(paddr, `ADDR_ISW) | hit(paddr, `ADDR_PSW) |
        hit(paddr, `ADDR_STAT) | hit(paddr, `ADDR_IRQ_ST) | hit(paddr, `ADDR_IRQ_MASK);
    assign pslverr = psel & penable & ~mapped;
    assign cmd_wr = wr & hit(paddr, `ADDR_CMD);
    assign cmd = pwdata[`CMD_CODE_W-1:0];
    assign rd_irq = rd & hit(paddr, `ADDR_IRQ_ST);

    assign drag = ctrl_q[`CTRL_DRAG];
    // Keep-driver is ignored unless background tasking is on
    assign keep_drv = ctrl_q[`CTRL_KEEP] & ctrl_q[`CTRL_BGTASK];
    // Drag mode masks both error-limit events, so no flags
    assign mv_ev = move_err_event & ~drag;
    assign hd_ev = hold_err_event & ~drag;

    // Internal flags merge live status with sticky error bits
    assign status_eff = status_in | isw_q;

    trip_match #(
        .W(W)
    ) u_match (
        .status(status_eff),
        .cond_en(cond_en_q),
        .cond_st(cond_st_q),
        .trip(trip)
    );

    assign trip_rise = trip & ~trip_prev_q;
    assign irq = |(irq_st_q & irq_mask_q);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 3'h0;
            cond_en_q <= {W{1'b0}};
            cond_st_q <= {W{1'b0}};
            recov_q <= 9'h000;
            irq_mask_q <= {`IRQ_W{1'b0}};
        end else if (cmd_wr && cmd == `CMD_RESTART) begin
            ctrl_q <= 3'h0;
            cond_en_q <= {W{1'b0}};
            cond_st_q <= {W{1'b0}};
            recov_q <= 9'h000;
            irq_mask_q <= {`IRQ_W{1'b0}};
        end else if (wr) begin
            if (hit(paddr, `ADDR_CTRL)) begin
                ctrl_q <= pwdata[2:0];
            end
            if (hit(paddr, `ADDR_COND_EN)) begin
                cond_en_q <= pwdata[W-1:0];
            end
            if (hit(paddr, `ADDR_COND_ST)) begin
                cond_st_q <= pwdata[W-1:0];
            end
            if (hit(paddr, `ADDR_RECOV)) begin
                recov_q <= pwdata[8:0];
            end
            if (hit(paddr, `ADDR_IRQ_MASK)) begin
                irq_mask_q <= pwdata[`IRQ_W-1:0];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isw_q <= {W{1'b0}};
            psw_q <= 3'h0;
            irq_st_q <= {`IRQ_W{1'b0}};
            trip_prev_q <= 1'b0;
            pos_err_q <= {PERR_W{1'b0}};
        end else if (cmd_wr && cmd == `CMD_RESTART) begin
            isw_q <= {W{1'b0}};
            psw_q <= 3'h0;
            irq_st_q <= {`IRQ_W{1'b0}};
            trip_prev_q <= 1'b0;
            pos_err_q <= {PERR_W{1'b0}};
        end else begin
            trip_prev_q <= trip;
            // Set beats clear in the same cycle
            isw_q[`BIT_MOVE_ERR] <= mv_ev |
                (isw_q[`BIT_MOVE_ERR] & ~(cmd_wr && cmd == `CMD_CIS));
            isw_q[`BIT_HOLD_ERR] <= hd_ev |
                (isw_q[`BIT_HOLD_ERR] & ~(cmd_wr && cmd == `CMD_CIS));
            psw_q[`PSW_MOVE_ERR] <= mv_ev |
                (psw_q[`PSW_MOVE_ERR] & ~(cmd_wr && cmd == `CMD_CPL));
            psw_q[`PSW_HOLD_ERR] <= hd_ev |
                (psw_q[`PSW_HOLD_ERR] & ~(cmd_wr && cmd == `CMD_CPL));
            // Host polls this flag when no recovery program is set
            psw_q[`PSW_KILLED] <= trip_rise |
                (psw_q[`PSW_KILLED] & ~(cmd_wr && cmd == `CMD_CPL));
            irq_st_q[`IRQ_TRIP] <= trip_rise | (irq_st_q[`IRQ_TRIP] & ~rd_irq);
            irq_st_q[`IRQ_ERRLIM] <= mv_ev | hd_ev | (irq_st_q[`IRQ_ERRLIM] & ~rd_irq);
            // Held at zero one more cycle while the far side drops its error
            if ((cmd_wr && cmd == `CMD_TTP) || pos_err_clear_q) begin
                pos_err_q <= {PERR_W{1'b0}};
            end else begin
                pos_err_q <= pos_err_in;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            driver_enable_q <= 1'b1;
            winding_short_q <= 1'b0;
            motion_abort_q <= 1'b0;
            motion_allow_q <= 1'b1;
            recov_start_q <= 1'b0;
            recov_prog_q <= `DEFAULT_PROG;
            recov_run_q <= 1'b0;
            restart_q <= 1'b0;
            pos_err_clear_q <= 1'b0;
        end else begin
            recov_start_q <= 1'b0;
            motion_abort_q <= 1'b0;
            restart_q <= 1'b0;
            pos_err_clear_q <= cmd_wr && cmd == `CMD_TTP;
            if (cmd_wr && cmd == `CMD_RESTART) begin
                restart_q <= 1'b1;
                recov_prog_q <= `DEFAULT_PROG;
                recov_start_q <= 1'b1;
                recov_run_q <= 1'b0;
                driver_enable_q <= 1'b1;
                winding_short_q <= 1'b0;
                motion_allow_q <= 1'b1;
            end else if (trip_rise) begin
                if (keep_drv) begin
                    // Driver stays on; motion in flight finishes unless recov_override aborts it
                    motion_abort_q <= recov_override;
                end else begin
                    driver_enable_q <= 1'b0;
                    winding_short_q <= 1'b1;
                    motion_abort_q <= 1'b1;
                    motion_allow_q <= 1'b0;
                end
                if (recov_q[`RECOV_EN]) begin
                    recov_prog_q <= recov_q[7:0];
                    recov_start_q <= 1'b1;
                    recov_run_q <= 1'b1;
                end
            end else if (cmd_wr && cmd == `CMD_DRV_EN) begin
                driver_enable_q <= 1'b1;
                winding_short_q <= 1'b0;
                motion_allow_q <= 1'b1;
            end else if (cmd_wr && cmd == `CMD_DRV_DIS) begin
                driver_enable_q <= 1'b0;
                winding_short_q <= 1'b1;
                motion_allow_q <= 1'b0;
            end else if (recov_run_q && recov_override && motion_busy) begin
                motion_abort_q <= 1'b1;
                recov_run_q <= 1'b0;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h00000000;
            if (hit(paddr, `ADDR_CTRL)) begin
                prdata[2:0] <= ctrl_q;
            end
            if (hit(paddr, `ADDR_COND_EN)) begin
                prdata[W-1:0] <= cond_en_q;
            end
            if (hit(paddr, `ADDR_COND_ST)) begin
                prdata[W-1:0] <= cond_st_q;
            end
            if (hit(paddr, `ADDR_RECOV)) begin
                prdata[8:0] <= recov_q;
            end
            if (hit(paddr, `ADDR_ISW)) begin
                prdata[W-1:0] <= status_eff;
            end
            if (hit(paddr, `ADDR_PSW)) begin
                prdata[2:0] <= psw_q;
            end
            if (hit(paddr, `ADDR_STAT)) begin
                prdata[`STAT_DRV] <= driver_enable_q;
                prdata[`STAT_MOTION_OK] <= motion_allow_q;
                prdata[`STAT_RECOV_RUN] <= recov_run_q;
                prdata[`STAT_ABORT] <= motion_abort_q;
                prdata[`STAT_SHORT] <= winding_short_q;
            end
            if (hit(paddr, `ADDR_IRQ_ST)) begin
                prdata[`IRQ_W-1:0] <= irq_st_q;
            end
            if (hit(paddr, `ADDR_IRQ_MASK)) begin
                prdata[`IRQ_W-1:0] <= irq_mask_q;
            end
        end
    end
endmodule // kill_shutdown

// File: verif/kill_shutdown_checker.sv
`timescale 1ns/10ps
`include "kill_defs.vh"
module kill_shutdown_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire driver_enable_q,
    input wire winding_short_q,
    input wire motion_abort_q,
    input wire motion_allow_q,
    input wire restart_q,
    input wire pos_err_clear_q,
    input wire [7:0] recov_prog_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire cmd = acc && pwrite && paddr == `ADDR_CMD;
    wire drv_dis = cmd && pwdata[7:0] == `CMD_DRV_DIS;
    // Unaligned offsets and those above the interrupt mask are unmapped
    wire bad = paddr[1:0] != 2'h0 || paddr > `ADDR_IRQ_MASK;
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_unmapped_err: assert property (acc |-> pslverr == bad)
        else $error("pslverr wrong");
    a_unmapped_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_short_drops: assert property (winding_short_q |-> !driver_enable_q && !motion_allow_q)
        else $error("windings shorted with driver on");
    a_abort_on_short: assert property ($rose(winding_short_q) && !$past(drv_dis)
        |-> motion_abort_q)
        else $error("no abort at shutdown");
    a_restart_cmd: assert property (cmd && pwdata[7:0] == `CMD_RESTART
        |=> restart_q && recov_prog_q == `DEFAULT_PROG && driver_enable_q)
        else $error("restart not done");
    a_ttp_cmd: assert property (cmd && pwdata[7:0] == `CMD_TTP |=> pos_err_clear_q)
        else $error("no error clear");
    a_drv_en_cmd: assert property (cmd && pwdata[7:0] == `CMD_DRV_EN
        |=> driver_enable_q && motion_allow_q && !winding_short_q)
        else $error("driver not enabled");
    a_drv_dis_cmd: assert property (cmd && pwdata[7:0] == `CMD_DRV_DIS
        |=> !driver_enable_q && !motion_allow_q)
        else $error("driver not disabled");
endmodule // kill_shutdown_checker
bind kill_shutdown kill_shutdown_checker i_kill_shutdown_checker (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .driver_enable_q(driver_enable_q), .winding_short_q(winding_short_q),
    .motion_abort_q(motion_abort_q), .motion_allow_q(motion_allow_q),
    .restart_q(restart_q), .pos_err_clear_q(pos_err_clear_q), .recov_prog_q(recov_prog_q));

// File: verif/plant_model.sv
`timescale 1ns/10ps
module plant_model #(
    parameter LIMIT = 16'h0010
) (
    input wire pclk,
    input wire presetn,
    input wire driver_on,
    input wire err_clear,
    input wire load,
    output logic [15:0] pos_err,
    output wire move_err,
    output wire busy
);
    // Error only builds while the driver pushes against the load
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pos_err <= 16'h0000;
        else if (err_clear)
            pos_err <= 16'h0000;
        else if (load && driver_on)
            pos_err <= pos_err + 16'h0001;
    end
    assign move_err = pos_err > LIMIT;
    assign busy = load;
endmodule // plant_model

// File: verif/tb_kill_shutdown.sv
`timescale 1ns/10ps
`include "kill_defs.vh"
module tb_kill_shutdown;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, push = 0, ovr = 0;
    logic hold = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [15:0] status_in = 16'h2000;
    wire [31:0] prdata;
    wire [15:0] pos_err_in, pos_err_q;
    wire [7:0] prog;
    wire pready, pslverr, move_err, busy, drv, shrt, abrt, allow, rs, rst, clr, irq;
    int num_errors = 0, n_checks = 0, n_rs = 0, n_ab = 0, n_rst = 0;
    initial forever #2.5 pclk = ~pclk;
    // Pulses are tallied on the falling edge so checks never race them
    always @(negedge pclk) begin
        n_rs += rs;
        n_ab += abrt;
        n_rst += rst;
    end
    kill_shutdown i_kill_shutdown (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .status_in(status_in), .move_err_event(move_err),
        .hold_err_event(hold), .pos_err_in(pos_err_in), .motion_busy(busy),
        .recov_override(ovr), .driver_enable_q(drv), .winding_short_q(shrt),
        .motion_abort_q(abrt), .motion_allow_q(allow), .recov_start_q(rs),
        .recov_prog_q(prog), .restart_q(rst), .pos_err_clear_q(clr),
        .pos_err_q(pos_err_q), .irq(irq));
    plant_model i_plant_model (.pclk(pclk), .presetn(presetn), .driver_on(drv),
        .err_clear(clr), .load(push), .pos_err(pos_err_in), .move_err(move_err), .busy(busy));
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) begin
            num_errors++;
            end_sim;
        end
        @(posedge pclk);
    endtask
    task rdc(input string s, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(0, a, 0);
        chk(s, e, rd & m);
    endtask
    task trip(input logic [15:0] s);
        status_in <= 16'h2000;
        @(posedge pclk);
        status_in <= s;
        repeat (3) @(posedge pclk);
    endtask
    task grow;
        int n;
        push <= 1;
        for (n = 0; n < 100 && move_err !== 1'b1; n++) @(posedge pclk);
        push <= 0;
        if (move_err !== 1'b1) begin
            chk("move_err", 1, move_err);
            end_sim;
        end
        repeat (2) @(posedge pclk);
        chk("perr", pos_err_in, pos_err_q);
        apb(1, `ADDR_CMD, `CMD_TTP);
        @(posedge pclk);
        chk("ttp", 0, pos_err_q);
    endtask
    task t_trip;
        int a0;
        chk("reset drv", 2'b11, {drv, allow});
        rdc("stat", `ADDR_STAT, 32'h1F, 32'h03);
        apb(1, `ADDR_IRQ_MASK, 3);
        apb(1, `ADDR_COND_ST, 3);
        apb(1, `ADDR_COND_EN, 1);
        trip(16'h2002);
        chk("masked bit", 1, drv);
        a0 = n_ab;
        trip(16'h2003);
        chk("drop", 4'b0101, {drv, shrt, allow, irq});
        chk("abort", 1, n_ab - a0);
        rdc("irq st", `ADDR_IRQ_ST, 3, 1);
        rdc("killed", `ADDR_PSW, 4, 4);
        chk("irq clr", 0, irq);
        trip(16'h2000);
        apb(1, `ADDR_CMD, `CMD_DRV_EN);
        chk("reenable", 3'b101, {drv, shrt, allow});
        trip(16'h0000);
        chk("overvolt", 0, drv);
        trip(16'h2000);
        apb(1, `ADDR_CMD, `CMD_DRV_EN);
        $display("trip test done");
    endtask
    task t_keep;
        int a0;
        int r0;
        apb(1, `ADDR_IRQ_MASK, 2);
        apb(1, `ADDR_CTRL, 3);
        apb(1, `ADDR_RECOV, 32'h15A);
        a0 = n_ab;
        r0 = n_rs;
        trip(16'h2001);
        chk("keep", 3'b110, {drv, allow, irq});
        chk("recov", 1, n_rs - r0);
        chk("prog", 8'h5A, prog);
        chk("no abort", 0, n_ab - a0);
        ovr <= 1;
        trip(16'h2001);
        chk("override drv", 1, drv);
        chk("override abort", 1, n_ab - a0);
        push <= 1;
        repeat (2) @(posedge pclk);
        push <= 0;
        chk("busy abort", 2, n_ab - a0);
        rdc("recov run", `ADDR_STAT, 4, 0);
        ovr <= 0;
        apb(1, `ADDR_CTRL, 1);
        trip(16'h2001);
        chk("no tasking", 0, drv);
        trip(16'h2000);
        apb(1, `ADDR_CMD, `CMD_DRV_EN);
        $display("keep test done");
    endtask
    task t_errlim;
        apb(1, `ADDR_CTRL, 0);
        apb(1, `ADDR_COND_EN, 0);
        apb(1, `ADDR_CMD, `CMD_CPL);
        apb(0, `ADDR_IRQ_ST, 0);
        grow;
        rdc("psw", `ADDR_PSW, 1, 1);
        rdc("isw", `ADDR_ISW, 16, 16);
        chk("irq", 1, irq);
        apb(1, `ADDR_CMD, `CMD_CIS);
        rdc("isw clr", `ADDR_ISW, 16, 0);
        hold <= 1;
        @(posedge pclk);
        hold <= 0;
        rdc("isw hold", `ADDR_ISW, 32'h30, 32'h20);
        rdc("psw hold", `ADDR_PSW, 3, 3);
        apb(1, `ADDR_CMD, `CMD_CPL);
        apb(1, `ADDR_CTRL, 4);
        hold <= 1;
        grow;
        hold <= 0;
        rdc("drag", `ADDR_PSW, 3, 0);
        $display("error limit test done");
    endtask
    task t_restart;
        int r0;
        apb(1, `ADDR_CMD, `CMD_DRV_DIS);
        chk("dis", 0, {drv, allow});
        apb(1, `ADDR_CTRL, 3);
        r0 = n_rst;
        apb(1, `ADDR_CMD, `CMD_RESTART);
        chk("restart", 1, n_rst - r0);
        rdc("ctrl", `ADDR_CTRL, 7, 0);
        rdc("recov", `ADDR_RECOV, 32'h1FF, 0);
        chk("drv", 2'b11, {drv, allow});
        rdc("unmapped", 12'h030, 32'hFFFFFFFF, 0);
        $display("restart test done");
    endtask
    task end_sim;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_trip;
        t_keep;
        t_errlim;
        t_restart;
        end_sim;
    end
    initial begin
        #100000;
        num_errors++;
        end_sim;
    end
endmodule // tb_kill_shutdown
